// file: core/itbu_pkg.sv
// Package: register map, field positions and state layout of the interrupt and time base unit
package itbu_pkg;
	// Register offsets
	localparam logic [3:0] ADDR_CTRL0 = 4'h0;
	localparam logic [3:0] ADDR_CTRL1 = 4'h1;
	localparam logic [3:0] ADDR_GRP0  = 4'h2;
	localparam logic [3:0] ADDR_GRP1  = 4'h3;
	localparam logic [3:0] ADDR_GRP2  = 4'h4;
	localparam logic [3:0] ADDR_EDGE  = 4'h5;
	localparam logic [3:0] ADDR_PSCS  = 4'h6;
	localparam logic [3:0] ADDR_TBCTL = 4'h7;
	localparam logic [3:0] ADDR_STAT  = 4'h8;
	// Field positions
	localparam int CTRL0_GIE    = 0;
	localparam int CTRL0_EXT_EN = 1;
	localparam int CTRL0_TICK_EN= 2;
	localparam int CTRL0_EXT_F  = 4;
	localparam int CTRL0_TICK_F = 5;
	localparam int CTRL1_GRP_EN = 0;
	localparam int CTRL1_CONV_EN= 3;
	localparam int CTRL1_GRP_F  = 4;
	localparam int CTRL1_CONV_F = 7;
	localparam int GRP_EN       = 0;
	localparam int GRP_F        = 4;
	localparam int TBCTL_RUN    = 7;
	localparam int TBCTL_PER    = 0;
	localparam int STAT_REQ     = 7;
	localparam int STAT_VEC     = 0;
	// Edge select and prescaler source codes
	localparam logic [1:0] EDGE_OFF  = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] PSC_SYS   = 2'h0;
	localparam logic [1:0] PSC_SYS4  = 2'h1;
	localparam logic [1:0] DIV4_LAST = 2'h3;
	// Time base period base value, counter width and idle read byte
	localparam int          TICK_W    = 15;
	localparam logic [15:0] TICK_BASE = 16'h0100;
	localparam logic [7:0]  RST_BYTE  = 8'h00;

	typedef enum logic [2:0] {
		VEC_EXT, VEC_GRP0, VEC_TICK, VEC_GRP1, VEC_GRP2, VEC_CONV
	} itbu_vec_t;

	// Member sources: 0/1 standard timer A/P, 2/3 periodic timer A/P, 4 low supply, 5 nvm
	typedef struct packed {
		logic nvm_done;
		logic low_supply;
		logic per_match_p;
		logic per_match_a;
		logic std_match_p;
		logic std_match_a;
	} itbu_evt_t;

	typedef struct packed {
		logic              gie;
		logic              ext_en;
		logic              tick_en;
		logic              conv_en;
		logic [2:0]        grp_en;
		logic              ext_f;
		logic              tick_f;
		logic              conv_f;
		logic [2:0]        grp_f;
		logic [5:0]        mem_en;
		logic [5:0]        mem_f;
		logic [1:0]        edge_sel;
		logic [1:0]        psc_sel;
		logic              tick_run;
		logic [2:0]        tick_per;
		logic [1:0]        div4;
		logic [TICK_W-1:0] tick_cnt;
		logic [2:0]        ext_sync;
		logic [2:0]        sub_sync;
		logic              irq_req;
		itbu_vec_t         irq_vec;
		logic              wake;
		logic [7:0]        rdata;
	} itbu_state_t;
endpackage : itbu_pkg

// file: core/itbu_top.sv
// Interrupt request logic with external edge, converter, time base and grouped sources
//
// Function
// RQ1 - External edge: rising, falling, both, or off
// RQ2 - Conversion done sets converter flag
// RQ3 - Converter vectors with global, enable, stack room
// RQ4 - Converter service clears its flag and global
// RQ5 - Time base overflow sets flag, gated vectoring
// RQ6 - Time base service clears flag and global
// RQ7 - Prescaler source: system, system/4, sub clock
// RQ8 - Time base run bit, reset zero
// RQ9 - Period is two to eight plus field
// RQ10 - Three grouped interrupts from member flags
// RQ11 - Member flag setting sets group flag; here only a source event on an enabled member sets it
// RQ12 - Group vectors when enabled with stack room
// RQ13 - Group service clears group flag, members stay
// RQ14 - Two timers, two match flags each
// RQ15 - Timer match needs global, source, group enables
// RQ16 - Low supply flag, gated by three enables
// RQ17 - Nvm completion flag, gated by three enables
// RQ18 - Any flag rising wakes the device
// RQ19 - Software presets flag to block wake
// RQ20 - Flags hold until serviced or cleared
// RQ21 - Global enable low blocks every vector
// RQ22 - Return from irq sets global enable
// RQ23 - Fixed priority, one service at a time
//
// Decided for this implementation: the placing of the registers and strobed register access.
module itbu_top (
	// Clock and reset
	input  wire logic                ref_clk_i,
	input  wire logic                rst_i,
	// Register port
	input  wire logic [3:0]          addr_i,
	input  wire logic [7:0]          wdata_i,
	input  wire logic                we_i,
	input  wire logic                re_i,
	output logic      [7:0]          rdata_o,
	// Event sources
	input  wire logic                ext_pin_i,
	input  wire logic                sub_clk_i,
	input  wire logic                conv_done_i,
	input  wire itbu_pkg::itbu_evt_t mem_evt_i,
	// Core side
	input  wire logic                stack_full_i,
	input  wire logic                irq_ack_i,
	input  wire logic                return_from_irq_i,
	output logic                     irq_req_o,
	output itbu_pkg::itbu_vec_t      irq_vec_o,
	output logic                     wake_o
);

	////////////////////////////////////////////////////////////////////////////////
	// State and combinational helpers

	itbu_pkg::itbu_state_t s_q;
	itbu_pkg::itbu_state_t s_d;

	logic                        psc_tick;
	logic                        ext_rise;
	logic                        ext_fall;
	logic                        ext_hit;
	logic                        sub_rise;
	logic [15:0]                 per_span;
	logic [itbu_pkg::TICK_W-1:0] per_mask;
	logic                        tick_ovf;
	logic [5:0]                  evt_vec;
	logic [2:0]                  grp_hit;
	logic [11:0]                 flags_q;

	assign ext_rise = s_q.ext_sync[1] & ~s_q.ext_sync[2];
	assign ext_fall = ~s_q.ext_sync[1] & s_q.ext_sync[2];
	assign sub_rise = s_q.sub_sync[1] & ~s_q.sub_sync[2];
	assign evt_vec  = mem_evt_i;

	// Edge type selection, zero disables the pin
	always_comb begin
		case (s_q.edge_sel) // RQ1
			itbu_pkg::EDGE_OFF:  ext_hit = 1'b0;
			itbu_pkg::EDGE_RISE: ext_hit = ext_rise;
			itbu_pkg::EDGE_FALL: ext_hit = ext_fall;
			default:             ext_hit = ext_rise | ext_fall;
		endcase
	end

	// Prescaled clock enable
	always_comb begin
		if (s_q.psc_sel == itbu_pkg::PSC_SYS) begin // RQ7
			psc_tick = 1'b1;
		end else if (s_q.psc_sel == itbu_pkg::PSC_SYS4) begin
			psc_tick = (s_q.div4 == itbu_pkg::DIV4_LAST);
		end else begin
			psc_tick = sub_rise;
		end
	end

	// Overflow when the selected low bits are all ones
	assign per_span = (itbu_pkg::TICK_BASE << s_q.tick_per) - 16'h0001; // RQ9
	assign per_mask = per_span[itbu_pkg::TICK_W-1:0];
	assign tick_ovf = s_q.tick_run & psc_tick & ((s_q.tick_cnt & per_mask) == per_mask); // RQ5

	// A group is ready when it is enabled and pending and one enabled member is pending
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gen_grp
			assign grp_hit[g] = s_q.grp_f[g] & s_q.grp_en[g] & |(s_q.mem_f[2*g+:2] & s_q.mem_en[2*g+:2]); // RQ15
		end
	endgenerate

	assign flags_q = {s_q.ext_f, s_q.tick_f, s_q.conv_f, s_q.grp_f, s_q.mem_f};

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		s_d = s_q;

		// Synchronisers and prescaler
		s_d.ext_sync = {s_q.ext_sync[1:0], ext_pin_i};
		s_d.sub_sync = {s_q.sub_sync[1:0], sub_clk_i};
		s_d.div4     = s_q.div4 + 2'h1;
		if (!s_q.tick_run) begin // RQ8
			s_d.tick_cnt = '0;
		end else if (psc_tick) begin
			s_d.tick_cnt = s_q.tick_cnt + 1'b1;
		end

		// Register writes, writing a one also presets a flag
		if (we_i) begin
			if (addr_i == itbu_pkg::ADDR_CTRL0) begin
				s_d.gie     = wdata_i[itbu_pkg::CTRL0_GIE];
				s_d.ext_en  = wdata_i[itbu_pkg::CTRL0_EXT_EN];
				s_d.tick_en = wdata_i[itbu_pkg::CTRL0_TICK_EN];
				s_d.ext_f   = wdata_i[itbu_pkg::CTRL0_EXT_F];
				s_d.tick_f  = wdata_i[itbu_pkg::CTRL0_TICK_F];
			end else if (addr_i == itbu_pkg::ADDR_CTRL1) begin
				s_d.grp_en  = wdata_i[itbu_pkg::CTRL1_GRP_EN+:3];
				s_d.conv_en = wdata_i[itbu_pkg::CTRL1_CONV_EN];
				s_d.grp_f   = wdata_i[itbu_pkg::CTRL1_GRP_F+:3];
				s_d.conv_f  = wdata_i[itbu_pkg::CTRL1_CONV_F];
			end else if (addr_i == itbu_pkg::ADDR_GRP0) begin
				s_d.mem_en[1:0] = wdata_i[itbu_pkg::GRP_EN+:2];
				s_d.mem_f[1:0]  = wdata_i[itbu_pkg::GRP_F+:2];
			end else if (addr_i == itbu_pkg::ADDR_GRP1) begin
				s_d.mem_en[3:2] = wdata_i[itbu_pkg::GRP_EN+:2];
				s_d.mem_f[3:2]  = wdata_i[itbu_pkg::GRP_F+:2];
			end else if (addr_i == itbu_pkg::ADDR_GRP2) begin
				s_d.mem_en[5:4] = wdata_i[itbu_pkg::GRP_EN+:2];
				s_d.mem_f[5:4]  = wdata_i[itbu_pkg::GRP_F+:2];
			end else if (addr_i == itbu_pkg::ADDR_EDGE) begin
				s_d.edge_sel = wdata_i[1:0];
			end else if (addr_i == itbu_pkg::ADDR_PSCS) begin
				s_d.psc_sel = wdata_i[1:0];
			end else if (addr_i == itbu_pkg::ADDR_TBCTL) begin
				s_d.tick_run = wdata_i[itbu_pkg::TBCTL_RUN];
				s_d.tick_per = wdata_i[itbu_pkg::TBCTL_PER+:3];
			end
		end

		// Service clears only the serviced flag and the global enable
		if (irq_ack_i && s_q.irq_req) begin
			s_d.gie = 1'b0; // RQ4 RQ6 RQ13
			case (s_q.irq_vec)
				itbu_pkg::VEC_EXT:  s_d.ext_f    = 1'b0;
				itbu_pkg::VEC_TICK: s_d.tick_f   = 1'b0; // RQ6
				itbu_pkg::VEC_CONV: s_d.conv_f   = 1'b0; // RQ4
				itbu_pkg::VEC_GRP0: s_d.grp_f[0] = 1'b0; // RQ13
				itbu_pkg::VEC_GRP1: s_d.grp_f[1] = 1'b0;
				default:            s_d.grp_f[2] = 1'b0;
			endcase
		end
		if (return_from_irq_i) begin
			s_d.gie = 1'b1; // RQ22
		end

		// Hardware sets win over clears
		if (ext_hit) begin
			s_d.ext_f = 1'b1; // RQ1
		end
		if (tick_ovf) begin
			s_d.tick_f = 1'b1; // RQ5
		end
		if (conv_done_i) begin
			s_d.conv_f = 1'b1; // RQ2
		end
		for (int i = 0; i < 6; i++) begin
			if (evt_vec[i]) begin
				s_d.mem_f[i] = 1'b1; // RQ14 RQ16 RQ17
				if (s_q.mem_en[i]) begin
					s_d.grp_f[i/2] = 1'b1; // RQ10 RQ11
				end
			end
		end

		// Wake on any flag rising, enables ignored
		s_d.wake = |({s_d.ext_f, s_d.tick_f, s_d.conv_f, s_d.grp_f, s_d.mem_f} & ~flags_q); // RQ18

		// Fixed priority request from the settled next state
		s_d.irq_req = 1'b0;
		s_d.irq_vec = itbu_pkg::VEC_EXT;
		if (s_d.ext_f && s_d.ext_en) begin // RQ23
			s_d.irq_req = 1'b1;
			s_d.irq_vec = itbu_pkg::VEC_EXT;
		end else if (s_d.grp_f[0] && s_d.grp_en[0] && |(s_d.mem_f[1:0] & s_d.mem_en[1:0])) begin // RQ12 RQ15
			s_d.irq_req = 1'b1;
			s_d.irq_vec = itbu_pkg::VEC_GRP0;
		end else if (s_d.tick_f && s_d.tick_en) begin // RQ5
			s_d.irq_req = 1'b1;
			s_d.irq_vec = itbu_pkg::VEC_TICK;
		end else if (s_d.grp_f[1] && s_d.grp_en[1] && |(s_d.mem_f[3:2] & s_d.mem_en[3:2])) begin // RQ12
			s_d.irq_req = 1'b1;
			s_d.irq_vec = itbu_pkg::VEC_GRP1;
		end else if (s_d.grp_f[2] && s_d.grp_en[2] && |(s_d.mem_f[5:4] & s_d.mem_en[5:4])) begin // RQ16 RQ17
			s_d.irq_req = 1'b1;
			s_d.irq_vec = itbu_pkg::VEC_GRP2;
		end else if (s_d.conv_f && s_d.conv_en) begin // RQ3
			s_d.irq_req = 1'b1;
			s_d.irq_vec = itbu_pkg::VEC_CONV;
		end
		if (!s_d.gie || stack_full_i) begin
			s_d.irq_req = 1'b0; // RQ21 RQ3
		end

		// Read data, valid the cycle after the strobe
		s_d.rdata = itbu_pkg::RST_BYTE;
		if (re_i) begin
			if (addr_i == itbu_pkg::ADDR_CTRL0) begin
				s_d.rdata = {2'h0, s_q.tick_f, s_q.ext_f, 1'b0, s_q.tick_en, s_q.ext_en, s_q.gie};
			end else if (addr_i == itbu_pkg::ADDR_CTRL1) begin
				s_d.rdata = {s_q.conv_f, s_q.grp_f, s_q.conv_en, s_q.grp_en};
			end else if (addr_i == itbu_pkg::ADDR_GRP0) begin
				s_d.rdata = {2'h0, s_q.mem_f[1:0], 2'h0, s_q.mem_en[1:0]};
			end else if (addr_i == itbu_pkg::ADDR_GRP1) begin
				s_d.rdata = {2'h0, s_q.mem_f[3:2], 2'h0, s_q.mem_en[3:2]};
			end else if (addr_i == itbu_pkg::ADDR_GRP2) begin
				s_d.rdata = {2'h0, s_q.mem_f[5:4], 2'h0, s_q.mem_en[5:4]};
			end else if (addr_i == itbu_pkg::ADDR_EDGE) begin
				s_d.rdata = {6'h00, s_q.edge_sel};
			end else if (addr_i == itbu_pkg::ADDR_PSCS) begin
				s_d.rdata = {6'h00, s_q.psc_sel};
			end else if (addr_i == itbu_pkg::ADDR_TBCTL) begin
				s_d.rdata = {s_q.tick_run, 4'h0, s_q.tick_per};
			end else if (addr_i == itbu_pkg::ADDR_STAT) begin
				s_d.rdata = {s_q.irq_req, 4'h0, s_q.irq_vec};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			s_q <= '0; // RQ8
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata_o   = s_q.rdata;
	assign irq_req_o = s_q.irq_req;
	assign irq_vec_o = s_q.irq_vec;
	assign wake_o    = s_q.wake;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	AST_EDGE_OFF: assert property ( // RQ1
		(s_q.edge_sel == itbu_pkg::EDGE_OFF) && !(we_i && addr_i == itbu_pkg::ADDR_CTRL0) && !s_q.ext_f
		|=> !s_q.ext_f)
		else $error("external flag set while edge select is off");

	AST_CONV_SET: assert property ( // RQ2
		conv_done_i |=> s_q.conv_f)
		else $error("conversion done did not set converter flag");

	AST_CONV_VEC: assert property ( // RQ3
		(s_q.irq_req && s_q.irq_vec == itbu_pkg::VEC_CONV) |-> (s_q.conv_f && s_q.conv_en && $past(!stack_full_i)))
		else $error("converter vector without its conditions");

	AST_SERVICE_GIE: assert property ( // RQ4
		(irq_ack_i && s_q.irq_req && !return_from_irq_i) |=> (!s_q.gie && !s_q.irq_req))
		else $error("service left global enable set");

	AST_CONV_CLR: assert property ( // RQ4
		(irq_ack_i && s_q.irq_req && s_q.irq_vec == itbu_pkg::VEC_CONV && !conv_done_i) |=> !s_q.conv_f)
		else $error("converter flag not cleared by service");

	AST_TICK_STOP: assert property ( // RQ8
		!s_q.tick_run |=> (s_q.tick_cnt == '0) && !(s_q.tick_f && !$past(s_q.tick_f) && !$past(we_i)))
		else $error("time base active while stopped");

	AST_GRP_SET: assert property ( // RQ11
		(mem_evt_i.low_supply && s_q.mem_en[4]) |=> (s_q.grp_f[2] && s_q.mem_f[4]))
		else $error("member set did not set group flag");

	AST_GRP_KEEP: assert property ( // RQ13
		(irq_ack_i && s_q.irq_req && s_q.irq_vec == itbu_pkg::VEC_GRP2 && !we_i && !mem_evt_i.low_supply
			&& !mem_evt_i.nvm_done) |=> (s_q.mem_f[5:4] == $past(s_q.mem_f[5:4])))
		else $error("group service changed member flags");

	AST_WAKE: assert property ( // RQ18
		(s_q.conv_f && !$past(s_q.conv_f)) |-> s_q.wake)
		else $error("flag rise without wake");

	AST_HOLD: assert property ( // RQ20
		(s_q.tick_f && !irq_ack_i && !we_i) |=> s_q.tick_f)
		else $error("time base flag dropped without cause");

	AST_GIE_GATE: assert property ( // RQ21
		s_q.irq_req |-> s_q.gie)
		else $error("request raised with global enable low");

	AST_RETURN: assert property ( // RQ22
		(return_from_irq_i && !(we_i && addr_i == itbu_pkg::ADDR_CTRL0)) |=> s_q.gie)
		else $error("return did not set global enable");

	AST_GRP_VEC: assert property ( // RQ12 RQ15
		s_q.irq_req |-> (s_q.irq_vec != itbu_pkg::VEC_GRP0 || grp_hit[0]) && (s_q.irq_vec != itbu_pkg::VEC_GRP1 || grp_hit[1])
			&& (s_q.irq_vec != itbu_pkg::VEC_GRP2 || grp_hit[2]))
		else $error("group vector without enabled pending member");

	AST_TICK_SET: assert property ( // RQ5
		tick_ovf |=> s_q.tick_f)
		else $error("time base overflow did not set its flag");

	AST_TICK_CLR: assert property ( // RQ6
		(irq_ack_i && s_q.irq_req && s_q.irq_vec == itbu_pkg::VEC_TICK && !tick_ovf) |=> !s_q.tick_f)
		else $error("time base flag not cleared by service");

	AST_GRP_CLR: assert property ( // RQ13
		(irq_ack_i && s_q.irq_req && s_q.irq_vec == itbu_pkg::VEC_GRP2 && !(mem_evt_i.low_supply && s_q.mem_en[4])
			&& !(mem_evt_i.nvm_done && s_q.mem_en[5])) |=> !s_q.grp_f[2])
		else $error("group flag not cleared by service");

	AST_STACK_GATE: assert property ( // RQ3
		$past(stack_full_i) |-> !s_q.irq_req)
		else $error("request raised while stack full");

	AST_PRIO: assert property ( // RQ23
		(s_q.irq_req && s_q.irq_vec != itbu_pkg::VEC_EXT) |-> !(s_q.ext_f && s_q.ext_en))
		else $error("lower vector chosen over pending external");

	AST_MEM_SET: assert property ( // RQ14 RQ16 RQ17
		(evt_vec != 6'h00) |=> ((s_q.mem_f & $past(evt_vec)) == $past(evt_vec)))
		else $error("member event did not set its flag");

endmodule : itbu_top

// file: sim/itbu_core_model.sv
// Core-side model: takes a pending vector after a chosen delay
module itbu_core_model (
	// Clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	// Bench control
	input  wire logic       auto_i,
	input  wire logic [3:0] delay_i,
	// Core side
	input  wire logic       irq_req_i,
	output logic            irq_ack_o
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [3:0] wait_q;

	// Ack only while a request stands, one pulse per service
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || !irq_req_i || irq_ack_o) begin
			wait_q    <= 4'h0;
			irq_ack_o <= 1'b0;
		end else begin
			wait_q    <= wait_q + 4'h1;
			irq_ack_o <= auto_i && (wait_q >= delay_i);
		end
	end
endmodule : itbu_core_model

// file: sim/testbench.sv
// Self-checking bench for the interrupt and time base unit
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin failures++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end

module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	logic                ref_clk_i = 1'b0;
	logic                rst_i = 1'b1;
	logic [3:0]          addr_i = 4'h0;
	logic [7:0]          wdata_i = 8'h00;
	logic                we_i = 1'b0;
	logic                re_i = 1'b0;
	logic [7:0]          rdata_o;
	logic                ext_pin_i = 1'b0;
	logic                sub_clk_i = 1'b0;
	logic                conv_done_i = 1'b0;
	logic [5:0]          evt = 6'h00;
	itbu_pkg::itbu_evt_t mem_evt_i;
	logic                stack_full_i = 1'b0;
	logic                irq_ack_i;
	logic                return_from_irq_i = 1'b0;
	logic                irq_req_o;
	itbu_pkg::itbu_vec_t irq_vec_o;
	logic                wake_o;
	logic                auto_ack = 1'b0;
	logic [3:0]          ack_delay = 4'h0;
	logic [31:0]         seed = 32'h087100B6;
	logic [7:0]          rd;
	logic [3:0]          ga;
	int                  failures = 0;
	int                  n_compared = 0;
	int                  n;
	itbu_pkg::itbu_vec_t order [6] = '{itbu_pkg::VEC_EXT, itbu_pkg::VEC_GRP0, itbu_pkg::VEC_TICK,
		itbu_pkg::VEC_GRP1, itbu_pkg::VEC_GRP2, itbu_pkg::VEC_CONV};

	assign mem_evt_i = evt;
	always #5 ref_clk_i = ~ref_clk_i;
	always #35.3 sub_clk_i = ~sub_clk_i;

	itbu_top i_itbu_top (.ref_clk_i, .rst_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .ext_pin_i,
		.sub_clk_i, .conv_done_i, .mem_evt_i, .stack_full_i, .irq_ack_i, .return_from_irq_i,
		.irq_req_o, .irq_vec_o, .wake_o);
	itbu_core_model i_itbu_core_model (.ref_clk_i, .rst_i, .auto_i(auto_ack), .delay_i(ack_delay),
		.irq_req_i(irq_req_o), .irq_ack_o(irq_ack_i));

	////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [7:0] rw_mask(input int a);
		case (a)
			0: return 8'h37;
			1: return 8'hFF;
			5, 6: return 8'h03;
			7: return 8'h87;
			default: return 8'h33;
		endcase
	endfunction : rw_mask

	task automatic step(input int k = 1);
		repeat (k) begin
			we_i <= 1'b0;
			re_i <= 1'b0;
			@(posedge ref_clk_i);
		end
	endtask : step

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		addr_i  <= a;
		wdata_i <= d;
		we_i    <= 1'b1;
		re_i    <= 1'b0;
		@(posedge ref_clk_i);
	endtask : wr

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] ex, input string nm);
		addr_i <= a;
		re_i   <= 1'b1;
		we_i   <= 1'b0;
		@(posedge ref_clk_i);
		step();
		`CHK(nm, ex, rdata_o)
	endtask : rd_chk

	// One source pulse, reaction seen one cycle later
	task automatic fire(input int src, input logic ex_req, input logic ex_wake);
		if (src < 6) evt[src] <= 1'b1;
		else conv_done_i <= 1'b1;
		step();
		evt         <= 6'h00;
		conv_done_i <= 1'b0;
		step();
		`CHK("wake", ex_wake, wake_o)
		`CHK("request", ex_req, irq_req_o)
	endtask : fire

	task automatic serve(input itbu_pkg::itbu_vec_t ev);
		ack_delay <= 4'(rnd() & 32'h3);
		for (n = 0; irq_req_o !== 1'b1 && n < 600; n++) step();
		`CHK("request", 1'b1, irq_req_o)
		`CHK("vector", ev, irq_vec_o)
		auto_ack <= 1'b1;
		for (n = 0; irq_ack_i !== 1'b1 && n < 50; n++) step();
		auto_ack <= 1'b0;
		step();
	endtask : serve

	task automatic wait_wake(input int lim, output int k);
		k = 0;
		do begin
			step();
			k++;
		end while (wake_o !== 1'b1 && k < lim);
	endtask : wait_wake

	task automatic measure(input logic [7:0] ps, input logic [7:0] tb, input int ex, input int tol);
		int k;
		wr(itbu_pkg::ADDR_CTRL0, 8'h00);
		wr(itbu_pkg::ADDR_PSCS, ps);
		wr(itbu_pkg::ADDR_TBCTL, tb);
		wait_wake(70000, k);
		wr(itbu_pkg::ADDR_CTRL0, 8'h00);
		wait_wake(70000, k);
		k++;
		`CHK("period", ex, (k >= ex - tol && k <= ex + tol) ? ex : k)
	endtask : measure

	task automatic conclude();
		$display("Comparisons %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////
	initial begin
		repeat (95000) @(posedge ref_clk_i);
		failures++;
		conclude();
	end

	initial begin
		repeat (5) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		step();
		for (int a = 0; a < 16; a++) rd_chk(4'(a), 8'h00, "reset value");
		for (int a = 0; a < 8; a++) begin
			rd = 8'(rnd());
			wr(4'(a), rd);
			rd_chk(4'(a), rd & rw_mask(a), "readback");
		end
		for (int a = 7; a >= 0; a--) wr(4'(a), 8'h00);
		wr(4'h9, 8'hFF);
		rd_chk(4'h9, 8'h00, "unmapped");
		// Edge select codes
		wr(itbu_pkg::ADDR_CTRL0, 8'h02);
		for (int e = 0; e < 4; e++) begin
			wr(itbu_pkg::ADDR_EDGE, 8'(e));
			ext_pin_i <= 1'b1;
			step(6);
			rd_chk(itbu_pkg::ADDR_CTRL0, {3'h0, e[0], 4'h2}, "rise flag");
			wr(itbu_pkg::ADDR_CTRL0, 8'h02);
			ext_pin_i <= 1'b0;
			step(6);
			rd_chk(itbu_pkg::ADDR_CTRL0, {3'h0, e[1], 4'h2}, "fall flag");
			wr(itbu_pkg::ADDR_CTRL0, 8'h02);
		end
		// Time base spacing per source and period
		measure(8'h00, 8'h80, 256, 0);
		measure(8'h00, 8'h81, 512, 0);
		measure(8'h01, 8'h80, 1024, 0);
		measure(8'h02, 8'h80, 1807, 3);
		measure(8'h03, 8'h80, 1807, 3);
		measure(8'h00, 8'h87, 32768, 0);
		wr(itbu_pkg::ADDR_TBCTL, 8'h00);
		wr(itbu_pkg::ADDR_CTRL0, 8'h00);
		wait_wake(600, n);
		`CHK("stopped", 600, n)
		wr(itbu_pkg::ADDR_TBCTL, 8'h80);
		wr(itbu_pkg::ADDR_CTRL0, 8'h05);
		serve(itbu_pkg::VEC_TICK);
		rd_chk(itbu_pkg::ADDR_CTRL0, 8'h04, "tick served");
		wr(itbu_pkg::ADDR_TBCTL, 8'h00);
		// Converter source
		wr(itbu_pkg::ADDR_CTRL0, 8'h00);
		wr(itbu_pkg::ADDR_CTRL1, 8'h08);
		fire(6, 1'b0, 1'b1);
		rd_chk(itbu_pkg::ADDR_CTRL1, 8'h88, "conv flag");
		stack_full_i <= 1'b1;
		wr(itbu_pkg::ADDR_CTRL0, 8'h01);
		step(3);
		`CHK("stack full", 1'b0, irq_req_o)
		stack_full_i <= 1'b0;
		serve(itbu_pkg::VEC_CONV);
		rd_chk(itbu_pkg::ADDR_CTRL1, 8'h08, "conv cleared");
		rd_chk(itbu_pkg::ADDR_CTRL0, 8'h00, "global cleared");
		// Grouped members, all six
		wr(itbu_pkg::ADDR_CTRL1, 8'h07);
		for (int i = 0; i < 6; i++) begin
			ga = itbu_pkg::ADDR_GRP0 + 4'(i / 2);
			wr(itbu_pkg::ADDR_CTRL0, 8'h01);
			wr(ga, 8'h00);
			fire(i, 1'b0, 1'b1);
			rd_chk(ga, 8'h10 << (i % 2), "member flag");
			rd_chk(itbu_pkg::ADDR_CTRL1, 8'h07, "group idle");
			fire(i, 1'b0, 1'b0);
			wr(ga, 8'h01 << (i % 2));
			fire(i, 1'b1, 1'b1);
			serve(i < 2 ? itbu_pkg::VEC_GRP0 : i < 4 ? itbu_pkg::VEC_GRP1 : itbu_pkg::VEC_GRP2);
			rd_chk(ga, 8'h11 << (i % 2), "member kept");
			rd_chk(itbu_pkg::ADDR_CTRL1, 8'h07, "group cleared");
		end
		// Everything pending at once
		for (int a = 2; a < 5; a++) wr(4'(a), 8'h11);
		wr(itbu_pkg::ADDR_CTRL1, 8'hFF);
		wr(itbu_pkg::ADDR_CTRL0, 8'h37);
		for (int k = 0; k < 6; k++) begin
			serve(order[k]);
			return_from_irq_i <= 1'b1;
			step();
			return_from_irq_i <= 1'b0;
		end
		rd_chk(itbu_pkg::ADDR_CTRL0, 8'h07, "all served");
		rd_chk(itbu_pkg::ADDR_CTRL1, 8'h0F, "groups served");
		rd_chk(itbu_pkg::ADDR_GRP2, 8'h11, "members kept");
		conclude();
	end
endmodule : testbench
